//--- rccs_pkg.sv
// package: constants and types for the ratio channel config store
package rccs_pkg;
  localparam int RCCS_SLOTS = 20;
  localparam int RCCS_SLOT_W = 5;
  localparam logic [4:0] RCCS_SLOT_PREV = 5'h00;
  localparam logic [4:0] RCCS_SLOT_SAVE_MIN = 5'h01;
  localparam logic [4:0] RCCS_SLOT_MAX = 5'h13;
  localparam logic [7:0] RCCS_ERR_LOG = 8'h1B;
  localparam logic [7:0] RCCS_ERR_NONE = 8'h00;
  localparam int RCCS_VAL_W = 16;
  localparam logic [15:0] RCCS_VAL_ZERO = 16'h0000;
  localparam logic [15:0] RCCS_CALFAC_DEF = 16'h0064;
  localparam logic [15:0] RCCS_CALADJ_DEF = 16'h0064;
  localparam logic [15:0] RCCS_FULL_PCT = 16'h0064;
  localparam logic [2:0] RCCS_RANGE_AUTO = 3'h0;
  localparam logic [3:0] RCCS_FILT_AUTO = 4'h0;

  typedef enum logic [2:0] {
    RCCS_MODE_A    = 3'b000,
    RCCS_MODE_B    = 3'b001,
    RCCS_MODE_AMB  = 3'b010,
    RCCS_MODE_BMA  = 3'b011,
    RCCS_MODE_AOB  = 3'b100,
    RCCS_MODE_BOA  = 3'b101
  } rccs_mode_e;

  typedef enum logic [2:0] {
    RCCS_CMD_NONE   = 3'b000,
    RCCS_CMD_MODE   = 3'b001,
    RCCS_CMD_SELA   = 3'b010,
    RCCS_CMD_SELB   = 3'b011,
    RCCS_CMD_SAVE   = 3'b100,
    RCCS_CMD_RECALL = 3'b101,
    RCCS_CMD_ENTER  = 3'b110,
    RCCS_CMD_PRESET = 3'b111
  } rccs_cmd_e;

  typedef struct packed {
    logic [15:0] calFactor;
    logic [15:0] offset;
    logic [2:0] range;
    logic [3:0] filter;
    logic [15:0] calAdj;
  } rccs_sensor_s;

  typedef struct packed {
    rccs_mode_e mode;
    logic relOn;
    logic [15:0] relRef;
    logic oscOn;
    logic chanB;
    logic logUnits;
    rccs_sensor_s sensA;
    rccs_sensor_s sensB;
  } rccs_cfg_s;

  localparam rccs_sensor_s RCCS_SENS_DEF = '{calFactor: RCCS_CALFAC_DEF,
    offset: RCCS_VAL_ZERO, range: RCCS_RANGE_AUTO, filter: RCCS_FILT_AUTO,
    calAdj: RCCS_CALADJ_DEF};
  localparam rccs_cfg_s RCCS_CFG_DEF = '{mode: RCCS_MODE_A, relOn: 1'b0,
    relRef: RCCS_VAL_ZERO, oscOn: 1'b0, chanB: 1'b0, logUnits: 1'b1,
    sensA: RCCS_SENS_DEF, sensB: RCCS_SENS_DEF};
endpackage

//--- rccs_ratio_if.sv
// interface: ratio engine request and answer
`timescale 1ns/10ps
`default_nettype none
interface rccs_ratio_if;
  import rccs_pkg::*;
  logic go;
  logic bOverA;
  logic logUnits;
  logic signed [15:0] powA;
  logic signed [15:0] powB;
  logic signed [15:0] ratio;
  logic logErr;
  logic done;
  modport ctl (output go, output bOverA, output logUnits, output powA, output powB,
    input ratio, input logErr, input done);
  modport eng (input go, input bOverA, input logUnits, input powA, input powB,
    output ratio, output logErr, output done);
endinterface
`default_nettype wire

//--- rccs_ratio_eng.sv
// ratio engine: sensor ratio with log error checks
`timescale 1ns/10ps
`default_nettype none
module rccs_ratio_eng
  import rccs_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // engine side
  rccs_ratio_if.eng rif
);
  logic signed [15:0] num;
  logic signed [15:0] den;
  logic signed [31:0] scaled;
  logic signed [31:0] quot;

  always_comb
  begin
    num = rif.bOverA ? rif.powB : rif.powA;
    den = rif.bOverA ? rif.powA : rif.powB;
    scaled = 32'(num) * 32'(signed'({1'b0, RCCS_FULL_PCT}));
    quot = (den == 16'sh0000) ? 32'sh0 : scaled / 32'(den);
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rif.ratio <= 16'sh0000;
      rif.logErr <= 1'b0;
      rif.done <= 1'b0;
    end
    else
    begin
      rif.done <= rif.go;
      if (rif.go)
      begin
        rif.ratio <= quot[15:0];
        rif.logErr <= (den == 16'sh0000) || (rif.logUnits && quot < 0);
      end
    end
  end

  a_zero_den_err: assert property (@(posedge core_clk) disable iff (sys_rst)
    rif.go && rif.powB == 16'sh0000 && !rif.bOverA |=> rif.logErr && rif.done)
    else $error("zero denominator did not raise log error");
endmodule
`default_nettype wire

//--- rccs_top.sv
// top: mode, entry channel and configuration slot store
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - ratio of both sensor powers, percent in either unit
// - A-first modes pick channel A, else B
// - mode change flushes and refills filter
// - zero denominator raises log error 27
// - negative ratio in dB raises error 27
// - per-sensor cal, range, filter, limits, offset
// - ratio may be shown against reference
// - channel select steers parameter entry
// - preset makes channel A active
// - slot holds mode, rel, osc, chan, units, sensors
// - save slots 1-19, recall slots 0-19
// - slot 0 holds previous configuration
// - recall replaces current parameters
// - power-up recalls slot 0
// - cal adjust saved, internal cal not
// - preset loads slot 0 only with defaults
// - memory loss defaults slot 0, no error code raised
// - limits never saved
// - mode change ends reference mode
module rccs_top
  import rccs_pkg::*;
#(
  parameter int SLOTS = RCCS_SLOTS
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // command strobe and operands
  input wire logic cmdValid,
  input wire rccs_cmd_e cmdCode,
  input wire rccs_mode_e cmdMode,
  input wire logic [4:0] cmdSlot,
  input wire logic slotValid,
  // parameter entry for the active channel; shared settings and memory loss
  input wire logic parmWrite,
  input wire rccs_sensor_s parmValue,
  input wire logic [15:0] parmLimHi,
  input wire logic [15:0] parmLimLo,
  input wire logic relCmd,
  input wire logic relOnReq,
  input wire logic [15:0] relRefIn,
  input wire logic unitsWrite,
  input wire logic unitsLog,
  input wire logic oscWrite,
  input wire logic oscOnReq,
  input wire logic memLost,
  // sensor powers with offset and cal factor applied
  input wire logic signed [15:0] powA,
  input wire logic signed [15:0] powB,
  // state and results
  output logic [2:0] curMode,
  output logic chanB,
  output logic relOn,
  output logic logUnits,
  output logic oscOn,
  output rccs_sensor_s sensA,
  output rccs_sensor_s sensB,
  output logic [15:0] limHiA,
  output logic [15:0] limLoA,
  output logic [15:0] limHiB,
  output logic [15:0] limLoB,
  output logic filterFlush,
  output logic signed [15:0] ratioOut,
  output logic ratioValid,
  output logic [7:0] errCode,
  output logic slotReject,
  output logic restoring
);
  rccs_cfg_s cur;
  rccs_cfg_s slotMem [SLOTS];
  rccs_cfg_s next_cur;
  logic [1:0] pend;
  logic [4:0] pendSlot;
  logic pendSlotOk;
  logic bootPend;
  logic saveOk;
  logic recallOk;
  logic enterHit;
  logic changing;
  logic isRatio;
  logic signed [15:0] relRef;
  rccs_ratio_if rif ();

  localparam logic [1:0] PEND_NONE = 2'b00;
  localparam logic [1:0] PEND_SAVE = 2'b01;
  localparam logic [1:0] PEND_RECALL = 2'b10;

  rccs_ratio_eng u_eng (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .rif(rif.eng)
  );

  assign enterHit = cmdValid && cmdCode == RCCS_CMD_ENTER && pendSlotOk;
  assign saveOk = enterHit && pend == PEND_SAVE && pendSlot >= RCCS_SLOT_SAVE_MIN
    && pendSlot <= RCCS_SLOT_MAX;
  assign recallOk = enterHit && pend == PEND_RECALL && pendSlot <= RCCS_SLOT_MAX;
  assign isRatio = cur.mode == RCCS_MODE_AOB || cur.mode == RCCS_MODE_BOA;

  // next configuration from the command in hand
  always_comb
  begin
    next_cur = cur;
    if (bootPend)
      next_cur = slotMem[RCCS_SLOT_PREV];
    else if (recallOk)
      next_cur = slotMem[pendSlot];
    else if (cmdValid && cmdCode == RCCS_CMD_PRESET)
      next_cur = RCCS_CFG_DEF;
    else if (cmdValid && cmdCode == RCCS_CMD_MODE)
    begin
      next_cur.mode = cmdMode;
      next_cur.chanB = cmdMode[0];
      next_cur.relOn = 1'b0;
      next_cur.relRef = RCCS_VAL_ZERO;
    end
    else if (cmdValid && (cmdCode == RCCS_CMD_SELA || cmdCode == RCCS_CMD_SELB))
      next_cur.chanB = cmdCode == RCCS_CMD_SELB;
    else if (parmWrite)
    begin
      if (cur.chanB)
        next_cur.sensB = parmValue;
      else
        next_cur.sensA = parmValue;
    end
    else if (relCmd)
    begin
      next_cur.relOn = relOnReq;
      next_cur.relRef = relOnReq ? relRefIn : RCCS_VAL_ZERO;
    end
    else if (unitsWrite)
      next_cur.logUnits = unitsLog;
    else if (oscWrite)
      next_cur.oscOn = oscOnReq;
  end

  assign changing = !bootPend && next_cur != cur;

  // current configuration
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      cur <= RCCS_CFG_DEF;
    else
      cur <= next_cur;
  end

  // boot recall of the previous-state slot
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      bootPend <= 1'b1;
    else
      bootPend <= 1'b0;
  end

  // slot store; limits are not part of the stored record
  always_ff @(posedge core_clk)
  begin
    if (memLost || (cmdValid && cmdCode == RCCS_CMD_PRESET))
      slotMem[RCCS_SLOT_PREV] <= RCCS_CFG_DEF;
    else if (changing)
      slotMem[RCCS_SLOT_PREV] <= cur;
    if (saveOk)
      slotMem[pendSlot] <= cur;
  end

  // save/recall sequencer: command, slot, enter
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pend <= PEND_NONE;
      pendSlot <= RCCS_SLOT_PREV;
      pendSlotOk <= 1'b0;
    end
    else if (cmdValid && cmdCode == RCCS_CMD_SAVE)
    begin
      pend <= PEND_SAVE;
      pendSlotOk <= 1'b0;
    end
    else if (cmdValid && cmdCode == RCCS_CMD_RECALL)
    begin
      pend <= PEND_RECALL;
      pendSlotOk <= 1'b0;
    end
    else if (slotValid && pend != PEND_NONE)
    begin
      pendSlot <= cmdSlot;
      pendSlotOk <= 1'b1;
    end
    else if (cmdValid && cmdCode == RCCS_CMD_ENTER)
    begin
      pend <= PEND_NONE;
      pendSlotOk <= 1'b0;
    end
  end

  // rejection pulse for bad slot or missing slot
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      slotReject <= 1'b0;
    else
      slotReject <= cmdValid && cmdCode == RCCS_CMD_ENTER && pend != PEND_NONE
        && !saveOk && !recallOk;
  end

  // limits per sensor, held outside the stored record
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      limHiA <= RCCS_VAL_ZERO;
      limLoA <= RCCS_VAL_ZERO;
      limHiB <= RCCS_VAL_ZERO;
      limLoB <= RCCS_VAL_ZERO;
    end
    else if (parmWrite && !cur.chanB)
    begin
      limHiA <= parmLimHi;
      limLoA <= parmLimLo;
    end
    else if (parmWrite)
    begin
      limHiB <= parmLimHi;
      limLoB <= parmLimLo;
    end
  end

  // filter flush on any mode change
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      filterFlush <= 1'b0;
    else
      filterFlush <= next_cur.mode != cur.mode;
  end

  // ratio request every cycle in a ratio mode
  assign rif.go = isRatio && !sys_rst;
  assign rif.bOverA = cur.mode == RCCS_MODE_BOA;
  assign rif.logUnits = cur.logUnits;
  assign rif.powA = powA;
  assign rif.powB = powB;
  assign relRef = signed'(cur.relRef);

  // ratio result, optionally against the reference
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ratioOut <= 16'sh0000;
      ratioValid <= 1'b0;
      errCode <= RCCS_ERR_NONE;
    end
    else
    begin
      ratioValid <= rif.done && !rif.logErr && isRatio;
      errCode <= (rif.done && rif.logErr) ? RCCS_ERR_LOG : RCCS_ERR_NONE;
      if (rif.done && !rif.logErr)
        ratioOut <= cur.relOn ? 16'(rif.ratio - relRef) : rif.ratio;
    end
  end

  assign curMode = cur.mode;
  assign chanB = cur.chanB;
  assign relOn = cur.relOn;
  assign logUnits = cur.logUnits;
  assign oscOn = cur.oscOn;
  assign sensA = cur.sensA;
  assign sensB = cur.sensB;
  assign restoring = bootPend;

  a_mode_chan: assert property (@(posedge core_clk) disable iff (sys_rst)
    !bootPend && cmdValid && cmdCode == RCCS_CMD_MODE
    |=> chanB == $past(cmdMode[0]))
    else $error("mode did not set entry channel");
  a_mode_flush: assert property (@(posedge core_clk) disable iff (sys_rst)
    !bootPend && cmdValid && cmdCode == RCCS_CMD_MODE && cmdMode != cur.mode |=> filterFlush)
    else $error("mode change did not flush filter");
  a_mode_rel_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    !bootPend && cmdValid && cmdCode == RCCS_CMD_MODE |=> !relOn)
    else $error("mode change left reference mode on");
  a_preset_chan: assert property (@(posedge core_clk) disable iff (sys_rst)
    !bootPend && cmdValid && cmdCode == RCCS_CMD_PRESET |=> !chanB)
    else $error("preset did not select channel A");
  a_sel_chan: assert property (@(posedge core_clk) disable iff (sys_rst)
    !bootPend && cmdValid && cmdCode == RCCS_CMD_SELB |=> chanB)
    else $error("channel B select not taken");
  a_save_zero_rej: assert property (@(posedge core_clk) disable iff (sys_rst)
    cmdValid && cmdCode == RCCS_CMD_ENTER && pend == PEND_SAVE && pendSlotOk
    && pendSlot == RCCS_SLOT_PREV |=> slotReject)
    else $error("save to slot 0 was not rejected");
  a_reject_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    !bootPend && cmdValid && cmdCode == RCCS_CMD_ENTER && pend == PEND_RECALL && pendSlotOk
    && !parmWrite && !relCmd && !unitsWrite && !oscWrite
    && pendSlot > RCCS_SLOT_MAX |=> cur == $past(cur))
    else $error("rejected recall changed configuration");
  a_recall_load: assert property (@(posedge core_clk) disable iff (sys_rst)
    !bootPend && recallOk |=> cur == $past(slotMem[pendSlot]))
    else $error("recall did not load slot");
  a_log_error: assert property (@(posedge core_clk) disable iff (sys_rst)
    rif.done && rif.logErr |=> errCode == RCCS_ERR_LOG && !ratioValid)
    else $error("log error not reported");
endmodule
`default_nettype wire

//--- rccs_keypad.sv
// keypad model: single commands and store or recall key sequences
`timescale 1ns/10ps
`default_nettype none
module rccs_keypad
  import rccs_pkg::*;
(
  // clock
  input wire logic core_clk,
  // command lines
  output logic cmdValid,
  output rccs_cmd_e cmdCode,
  output rccs_mode_e cmdMode,
  output logic [4:0] cmdSlot,
  output logic slotValid
);
  initial
  begin
    cmdValid = 1'b0;
    cmdCode = RCCS_CMD_NONE;
    cmdMode = RCCS_MODE_A;
    cmdSlot = 5'h1F;
    slotValid = 1'b0;
  end
  // one key, held for one taking edge
  task automatic key(input rccs_cmd_e code, input rccs_mode_e mode);
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdCode <= code;
    cmdMode <= mode;
    @(posedge core_clk);
    cmdValid <= 1'b0;
    cmdCode <= rccs_cmd_e'(~code);
  endtask
  // function key, then slot number, then enter
  task automatic seq(input rccs_cmd_e code, input logic [4:0] slot);
    key(code, cmdMode);
    slotValid <= 1'b1;
    cmdSlot <= slot;
    @(posedge core_clk);
    slotValid <= 1'b0;
    cmdSlot <= ~slot;
    cmdValid <= 1'b1;
    cmdCode <= RCCS_CMD_ENTER;
    @(posedge core_clk);
    cmdValid <= 1'b0;
    cmdCode <= RCCS_CMD_NONE;
  endtask
endmodule
`default_nettype wire

//--- ratio_channel_config_store_tb.sv
// testbench: modes, entry channel, slots and ratio errors
`timescale 1ns/10ps
`default_nettype none
module ratio_channel_config_store_tb;
  import rccs_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmdValid, slotValid;
  rccs_cmd_e cmdCode;
  rccs_mode_e cmdMode;
  logic [4:0] cmdSlot;
  logic parmWrite = 1'b0, relCmd = 1'b0, relOnReq = 1'b0, unitsWrite = 1'b0;
  logic unitsLog = 1'b0, oscWrite = 1'b0, oscOnReq = 1'b0, memLost = 1'b1;
  rccs_sensor_s parmValue = RCCS_SENS_DEF;
  logic [15:0] parmLimHi = 16'h0000, parmLimLo = 16'h0000, relRefIn = 16'h0000;
  logic signed [15:0] powA = 16'h0064, powB = 16'h0064, ratioOut;
  logic [2:0] curMode;
  logic chanB, relOn, logUnits, oscOn, filterFlush, ratioValid, slotReject, restoring;
  rccs_sensor_s sensA, sensB;
  logic [15:0] limHiA, limLoA, limHiB, limLoB;
  logic [7:0] errCode;
  int fail_count = 0, checks = 0, cycles = 0;
  rccs_sensor_s v1 = '{16'h0050, 16'h0003, 3'h2, 4'h1, 16'h0062};
  rccs_sensor_s v2 = '{16'h0041, 16'h0007, 3'h4, 4'h3, 16'h0058};

  always #5 core_clk = ~core_clk;

  rccs_keypad u_keys (.core_clk(core_clk), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdMode(cmdMode), .cmdSlot(cmdSlot), .slotValid(slotValid));

  rccs_top #(.SLOTS(RCCS_SLOTS)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdMode(cmdMode), .cmdSlot(cmdSlot),
    .slotValid(slotValid), .parmWrite(parmWrite), .parmValue(parmValue),
    .parmLimHi(parmLimHi), .parmLimLo(parmLimLo), .relCmd(relCmd), .relOnReq(relOnReq),
    .relRefIn(relRefIn), .unitsWrite(unitsWrite), .unitsLog(unitsLog),
    .oscWrite(oscWrite), .oscOnReq(oscOnReq), .memLost(memLost), .powA(powA),
    .powB(powB), .curMode(curMode), .chanB(chanB), .relOn(relOn), .logUnits(logUnits),
    .oscOn(oscOn), .sensA(sensA), .sensB(sensB), .limHiA(limHiA), .limLoA(limLoA),
    .limHiB(limHiB), .limLoB(limLoB), .filterFlush(filterFlush), .ratioOut(ratioOut),
    .ratioValid(ratioValid), .errCode(errCode), .slotReject(slotReject),
    .restoring(restoring));

  task automatic final_report();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic parm(input rccs_sensor_s v, input logic [15:0] hi);
    @(posedge core_clk);
    parmValue <= v;
    parmLimHi <= hi;
    parmLimLo <= ~hi;
    parmWrite <= 1'b1;
    @(posedge core_clk);
    parmWrite <= 1'b0;
    #1;
  endtask

  // w bits: oscillator, units, reference
  task automatic ctl(input logic [2:0] w, input logic on);
    @(posedge core_clk);
    {oscWrite, unitsWrite, relCmd} <= w;
    {oscOnReq, unitsLog, relOnReq} <= {3{on}};
    @(posedge core_clk);
    {oscWrite, unitsWrite, relCmd} <= 3'h0;
    #1;
  endtask

  task automatic pow(input logic [15:0] a, input logic [15:0] b);
    @(posedge core_clk);
    powA <= a;
    powB <= b;
    tick(4);
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      final_report();
    end
  end

  initial
  begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    memLost <= 1'b0;
    #1;
    chk(restoring, 1'b1);
    tick(1);
    chk({restoring, curMode, chanB}, {1'b0, RCCS_MODE_A, 1'b0});
    u_keys.key(RCCS_CMD_PRESET, RCCS_MODE_A);
    tick(0);
    chk(chanB, 1'b0);
    chk(curMode, RCCS_MODE_A);
    for (int i = 5; i >= 0; i--)
    begin
      relRefIn <= 16'h0010;
      ctl(3'h1, 1'b1);
      chk(relOn, 1'b1);
      u_keys.key(RCCS_CMD_MODE, rccs_mode_e'(i));
      tick(0);
      chk(curMode, i);
      chk(chanB, i[0]);
      chk(relOn, 1'b0);
      chk(filterFlush, 1'b1);
      tick(1);
      chk(filterFlush, 1'b0);
    end
    parm(v2, 16'h5555);
    chk(sensA, v2);
    chk({limHiA, limLoA}, 32'h5555AAAA);
    u_keys.key(RCCS_CMD_SELB, RCCS_MODE_A);
    tick(0);
    chk({curMode, chanB}, {RCCS_MODE_A, 1'b1});
    parm(v1, 16'h1234);
    chk(sensB, v1);
    chk(sensA, v2);
    chk({limHiA, limHiB, limLoB}, 48'h5555_1234_EDCB);
    u_keys.seq(RCCS_CMD_SAVE, 5'h03);
    tick(0);
    chk(slotReject, 1'b0);
    parm(v2, 16'h0ABC);
    u_keys.seq(RCCS_CMD_RECALL, 5'h03);
    tick(0);
    chk(sensB, v1);
    chk(limHiB, 16'h0ABC);
    u_keys.seq(RCCS_CMD_RECALL, RCCS_SLOT_PREV);
    tick(0);
    chk(sensB, v2);
    for (int i = 0; i < 3; i++)
    begin
      u_keys.seq(i == 2 ? RCCS_CMD_RECALL : RCCS_CMD_SAVE, i == 0 ? 5'h00 : 5'h14);
      tick(0);
      chk(slotReject, 1'b1);
      chk(sensB, v2);
    end
    u_keys.key(RCCS_CMD_MODE, RCCS_MODE_AOB);
    ctl(3'h2, 1'b0);
    chk(logUnits, 1'b0);
    pow(16'h00C8, 16'h0064);
    chk({ratioValid, ratioOut}, {1'b1, 16'h00C8});
    relRefIn <= 16'h0032;
    ctl(3'h1, 1'b1);
    tick(4);
    chk(ratioOut, 16'h0096);
    ctl(3'h1, 1'b0);
    pow(16'h00C8, 16'h0000);
    chk({ratioValid, errCode}, {1'b0, RCCS_ERR_LOG});
    ctl(3'h2, 1'b1);
    pow(16'hFF9C, 16'h0064);
    chk(errCode, RCCS_ERR_LOG);
    ctl(3'h2, 1'b0);
    tick(4);
    chk({errCode, ratioOut}, {RCCS_ERR_NONE, 16'hFF9C});
    ctl(3'h4, 1'b1);
    chk(oscOn, 1'b1);
    u_keys.seq(RCCS_CMD_SAVE, 5'h05);
    @(posedge core_clk);
    memLost <= 1'b1;
    @(posedge core_clk);
    memLost <= 1'b0;
    u_keys.seq(RCCS_CMD_RECALL, RCCS_SLOT_PREV);
    tick(0);
    chk({curMode, oscOn, sensB}, {RCCS_MODE_A, 1'b0, RCCS_SENS_DEF});
    u_keys.seq(RCCS_CMD_RECALL, 5'h05);
    tick(0);
    chk({curMode, oscOn, logUnits, sensB}, {RCCS_MODE_AOB, 1'b1, 1'b0, v2});
    u_keys.key(RCCS_CMD_SELB, RCCS_MODE_A);
    u_keys.key(RCCS_CMD_SELA, RCCS_MODE_A);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk(restoring, 1'b1);
    tick(1);
    chk({restoring, chanB}, 2'h1);
    final_report();
  end
endmodule
`default_nettype wire
